// ==== hdl/flash_status_cfg.svh ====
// Constants for the flash status and protection register bank.
// Assumes inclusion by name from the package; the design module uses its macros without an include.
`ifndef FLASH_STATUS_CFG_SVH
`define FLASH_STATUS_CFG_SVH

// Instruction codes
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_WRITE_STATUS 8'h01
`define OP_WRITE_STATUS_MID 8'h31
`define OP_WRITE_STATUS_HIGH 8'h11
`define OP_READ_STATUS_LOW 8'h05
`define OP_READ_STATUS_MID 8'h35
`define OP_READ_STATUS_HIGH 8'h15
`define OP_SUSPEND 8'h75
`define OP_RESUME 8'h7A
`define OP_ENTER_FOUR_WIRE 8'h38
`define OP_EXIT_FOUR_WIRE 8'hFF
`define OP_ENTER_ADDR4 8'hB7
`define OP_EXIT_ADDR4 8'hE9
`define OP_PAGE_PROGRAM 8'h02
`define OP_SECTOR_ERASE 8'h20
`define OP_BLOCK_ERASE 8'hD8
`define OP_CHIP_ERASE 8'hC7

// Register reset values
`define SR_LOW_RESET 8'h00
`define SR_MID_RESET 8'h00
`define SR_HIGH_RESET 8'h00

// Byte positions of the registers in the read snapshot
`define SNAP_LOW_LSB 0
`define SNAP_MID_LSB 8
`define SNAP_HIGH_LSB 16

// Status-register write time, in cycles of the system clock
`define SR_WRITE_CYCLES 16

`endif

// ==== hdl/flash_status_pkg.sv ====
// Types for the flash status and protection register bank.
// Assumes the constants header is on the include path.
package flash_status_pkg;
  `include "flash_status_cfg.svh"

  // Low status register, bit 7 first
  typedef struct packed {
    logic status_protect_lower;
    logic [4:0] block_protect_field;
    logic write_enable_latch;
    logic busy_flag;
  } sr_low_t;

  // Middle status register
  typedef struct packed {
    logic erase_suspended_flag;
    logic complement_protect;
    logic [2:0] security_lock;
    logic program_suspended_flag;
    logic quad_enable_bit;
    logic status_protect_upper;
  } sr_mid_t;

  // High status register
  typedef struct packed {
    logic hold_or_reset_sel;
    logic [1:0] drive_strength;
    logic [1:0] reserved;
    logic protection_scheme_select;
    logic power_up_address_mode;
    logic current_address_mode;
  } sr_high_t;

  // One instruction from the serial front end
  typedef struct packed {
    logic [7:0] opcode;
    logic [23:0] data;
    logic [1:0] nbytes;
  } cmd_t;
endpackage : flash_status_pkg

// ==== hdl/flash_status_protection_regs.sv ====
// Status and configuration registers of a serial flash, with write protection.
// Assumes a serial front end on the link clock hands over decoded instructions,
// and that the array engine and pins are outside this module.
//
// Notes on behaviour
// (RULE_01) Busy flag high during program, erase, writes
// (RULE_02) Latch low rejects writes, programs and erases
// (RULE_03) Every status write clears the latch
// (RULE_04) Block-protect bits written; guard array when scheme=0
// (RULE_05) Block-protect writes need hardware protection off
// (RULE_06) Chip erase only with matching complement pattern; the code skips this check when protection_scheme_select is 1
// (RULE_07) Protect 00: write allowed with latch set
// (RULE_08) Protect 01: pin low locks, high allows
// (RULE_09) Protect 10: locked until power cycle, then 00
// (RULE_10) Protect 11: status writes refused forever; power-up reset here clears the pair to 00
// (RULE_11) Quad enable turns two pins into data
// (RULE_12) Four-wire entry ignored unless quad enabled
// (RULE_13) Four-wire mode keeps quad enable set
// (RULE_14) Security locks one-time set, lock register
// (RULE_15) Complement bit joins block-protect region select
// (RULE_16) Suspend sets flag; resume or power clears
// (RULE_17) Address-mode bit shows three or four bytes
// (RULE_18) Power-up address bit only via high write
// (RULE_19) Power-up address bit chooses start mode
// (RULE_20) Shared pin hold or reset when quad off
// (RULE_21) Scheme select one-time set; zero means block mode
// (RULE_22) Scheme one: per-block bits, dynamic bits set
// (RULE_23) Drive bits pick 100, 75, 50, 25 percent
// (RULE_24) Reserved high bits ignore writes
module flash_status_protection_regs #(
  parameter int SR_WRITE_CYCLES = `SR_WRITE_CYCLES
) (
  // System clock and power-up reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Device reset request (software or hardware), one-cycle pulse
  input wire logic i_dev_reset,
  // Array engine state
  input wire logic i_array_busy,
  input wire logic i_array_erasing,
  // Write-protect pin, asynchronous
  input wire logic i_wp_n,
  // Serial link side
  input wire logic i_clk_link,
  input wire logic i_cmd_valid,
  input wire flash_status_pkg::cmd_t i_cmd,
  output logic o_link_busy,
  output logic o_rd_valid,
  output logic [23:0] o_rd_data,
  // Array control
  output logic o_array_go,
  output logic [7:0] o_array_op,
  output logic o_suspend_req,
  output logic o_resume_req,
  output logic o_dpb_set_all,
  // Protection and configuration state
  output logic o_bp_enable,
  output logic [4:0] o_block_protect_field,
  output logic o_complement_protect,
  output logic [2:0] o_security_lock,
  output logic o_pins_quad,
  output logic o_hold_en,
  output logic o_reset_pin_en,
  output logic o_four_wire_mode,
  output logic o_addr4_mode,
  output logic [1:0] o_drive_strength
);
  import flash_status_pkg::*;

  // ----------------------------------------------------------------
  // Link domain state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic req_tog;       // Toggles once per handed-over instruction
    cmd_t cmd;           // Instruction held stable for the crossing
    logic ack_ff1;       // Acknowledge synchroniser, first stage
    logic ack_ff2;       // Acknowledge synchroniser, second stage
    logic ack_seen;      // Last acknowledge level consumed
    logic busy;          // Waiting for the system side
    logic rd_valid;      // Read data strobe
    logic [23:0] rd_data; // Register snapshot for the front end
  } link_state_t;

  // ----------------------------------------------------------------
  // System domain state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic req_ff1;       // Request synchroniser, first stage
    logic req_ff2;       // Request synchroniser, second stage
    logic req_seen;      // Last request level consumed
    logic ack_tog;       // Toggles when an instruction is done
    logic wp_ff1;        // Write-protect pin, first stage
    logic wp_ff2;        // Write-protect pin, second stage
    logic init;          // Power-up initialisation still pending
    logic four_wire;     // Four-wire instruction mode
    logic [15:0] timer;  // Remaining status-write busy cycles
    sr_low_t sr_low;
    sr_mid_t sr_mid;
    sr_high_t sr_high;
    logic [23:0] snap;   // Snapshot handed back to the link
    logic go;
    logic [7:0] op;
    logic sus_req;
    logic res_req;
    logic dpb_set;
  } sys_state_t;

  link_state_t link_reg, link_next;
  sys_state_t sys_reg, sys_next;

  // Combinational helpers of the system side
  logic busy_now;
  logic sr_locked;
  logic new_req;
  logic [7:0] b0;
  logic [7:0] b1;
  sr_low_t wr_low;
  sr_mid_t wr_mid;
  sr_high_t wr_high;
  logic chip_erase_ok;

  // ----------------------------------------------------------------
  // Link side: hand an instruction over and collect the answer
  // ----------------------------------------------------------------
  always_comb begin
    link_next = link_reg;
    link_next.rd_valid = 1'b0;
    // Second stage only reads the first
    link_next.ack_ff1 = sys_reg.ack_tog;
    link_next.ack_ff2 = link_reg.ack_ff1;
    if (i_cmd_valid && !link_reg.busy) begin
      // Hold the instruction and flip the request level
      link_next.cmd = i_cmd;
      link_next.req_tog = ~link_reg.req_tog;
      link_next.busy = 1'b1;
    end else if (link_reg.busy && (link_reg.ack_ff2 != link_reg.ack_seen)) begin
      // Snapshot is stable since the system edge that flipped the acknowledge
      link_next.ack_seen = link_reg.ack_ff2;
      link_next.busy = 1'b0;
      link_next.rd_valid = 1'b1;
      link_next.rd_data = sys_reg.snap;
    end
  end

  // Link side registers
  always_ff @(posedge i_clk_link or negedge i_nrst) begin
    if (!i_nrst) begin
      link_reg <= '0;
    end else begin
      link_reg <= link_next;
    end
  end

  // ----------------------------------------------------------------
  // System side: decode helpers
  // ----------------------------------------------------------------
  always_comb begin
    // Busy covers the array engine and the status-write time
    busy_now = i_array_busy || (sys_reg.timer != 16'h0000); // RULE_01
    // Status-register lock from the two protect bits and the pin
    case ({sys_reg.sr_mid.status_protect_upper, sys_reg.sr_low.status_protect_lower})
      2'b00: sr_locked = 1'b0; // RULE_07
      2'b01: sr_locked = !sys_reg.wp_ff2; // RULE_08
      2'b10, 2'b11: sr_locked = 1'b1; // RULE_09 RULE_10
      default: sr_locked = 1'b1;
    endcase
    new_req = (sys_reg.req_ff2 != sys_reg.req_seen);
    b0 = link_reg.cmd.data[7:0];
    b1 = link_reg.cmd.data[15:8];
    // Chip erase needs the low three guard bits to match the complement, unless the per-block scheme is selected
    chip_erase_ok = sys_reg.sr_high.protection_scheme_select
      || ((sys_reg.sr_low.block_protect_field[2:0] == 3'b000)
          && !sys_reg.sr_mid.complement_protect)
      || ((sys_reg.sr_low.block_protect_field[2:0] == 3'b111)
          && sys_reg.sr_mid.complement_protect); // RULE_06
    // Candidate low register after a write
    wr_low = sys_reg.sr_low;
    wr_low.status_protect_lower = b0[7];
    wr_low.block_protect_field = b0[6:2]; // RULE_04
    // Candidate middle register; suspend flags stay read-only
    wr_mid = sys_reg.sr_mid;
    wr_mid.status_protect_upper = b1[0];
    wr_mid.quad_enable_bit = b1[1] || sys_reg.four_wire; // RULE_13
    wr_mid.security_lock = sys_reg.sr_mid.security_lock | b1[5:3]; // RULE_14
    wr_mid.complement_protect = b1[6]; // RULE_15
    // Candidate high register; reserved bits and live mode untouched
    wr_high = sys_reg.sr_high; // RULE_24
    wr_high.power_up_address_mode = b0[1]; // RULE_18
    wr_high.protection_scheme_select =
      sys_reg.sr_high.protection_scheme_select | b0[2]; // RULE_21
    wr_high.drive_strength = b0[6:5]; // RULE_23
    wr_high.hold_or_reset_sel = b0[7];
  end

  // ----------------------------------------------------------------
  // System side: instruction execution
  // ----------------------------------------------------------------
  always_comb begin
    sys_next = sys_reg;
    sys_next.go = 1'b0;
    sys_next.sus_req = 1'b0;
    sys_next.res_req = 1'b0;
    sys_next.dpb_set = 1'b0;
    // Synchronisers: first stage only feeds the second
    sys_next.req_ff1 = link_reg.req_tog;
    sys_next.req_ff2 = sys_reg.req_ff1;
    sys_next.wp_ff1 = i_wp_n;
    sys_next.wp_ff2 = sys_reg.wp_ff1;
    // Status-write busy countdown
    if (sys_reg.timer != 16'h0000) begin
      sys_next.timer = sys_reg.timer - 16'h0001;
    end
    if (sys_reg.init || i_dev_reset) begin
      // Start-up address mode from the stored choice
      sys_next.init = 1'b0;
      sys_next.sr_high.current_address_mode =
        sys_reg.sr_high.power_up_address_mode; // RULE_19
      sys_next.sr_low.write_enable_latch = 1'b0;
      sys_next.sr_mid.erase_suspended_flag = 1'b0;
      sys_next.sr_mid.program_suspended_flag = 1'b0;
      sys_next.four_wire = 1'b0;
      sys_next.timer = 16'h0000;
      // Dynamic bits all set when the per-block scheme is active
      sys_next.dpb_set = sys_reg.sr_high.protection_scheme_select; // RULE_22
    end else if (new_req) begin
      sys_next.req_seen = sys_reg.req_ff2;
      sys_next.ack_tog = ~sys_reg.ack_tog;
      case (link_reg.cmd.opcode)
        `OP_WRITE_ENABLE: begin
          // Latch set for the next protected instruction
          sys_next.sr_low.write_enable_latch = 1'b1;
        end
        `OP_WRITE_DISABLE: begin
          sys_next.sr_low.write_enable_latch = 1'b0;
        end
        `OP_WRITE_STATUS, `OP_WRITE_STATUS_MID, `OP_WRITE_STATUS_HIGH: begin
          // Latch drops even when the write is refused
          sys_next.sr_low.write_enable_latch = 1'b0; // RULE_03
          if (sys_reg.sr_low.write_enable_latch && !busy_now
              && !sr_locked) begin // RULE_02 RULE_05
            sys_next.timer = 16'(SR_WRITE_CYCLES);
            if (link_reg.cmd.opcode == `OP_WRITE_STATUS) begin
              sys_next.sr_low.status_protect_lower = wr_low.status_protect_lower;
              sys_next.sr_low.block_protect_field = wr_low.block_protect_field;
              if (link_reg.cmd.nbytes >= 2'd2) begin
                sys_next.sr_mid = wr_mid;
              end
            end else if (link_reg.cmd.opcode == `OP_WRITE_STATUS_MID) begin
              // Single byte lands in the middle register
              sys_next.sr_mid = wr_mid;
              sys_next.sr_mid.status_protect_upper = b0[0];
              sys_next.sr_mid.quad_enable_bit = b0[1] || sys_reg.four_wire; // RULE_13
              sys_next.sr_mid.security_lock =
                sys_reg.sr_mid.security_lock | b0[5:3]; // RULE_14
              sys_next.sr_mid.complement_protect = b0[6];
            end else begin
              sys_next.sr_high = wr_high; // RULE_18
            end
          end
        end
        `OP_PAGE_PROGRAM, `OP_SECTOR_ERASE, `OP_BLOCK_ERASE, `OP_CHIP_ERASE: begin
          // Array work only with the latch set; latch drops regardless
          sys_next.sr_low.write_enable_latch = 1'b0;
          if (sys_reg.sr_low.write_enable_latch && !busy_now
              && ((link_reg.cmd.opcode != `OP_CHIP_ERASE) || chip_erase_ok)) begin // RULE_02
            sys_next.go = 1'b1;
            sys_next.op = link_reg.cmd.opcode;
          end
        end
        `OP_SUSPEND: begin
          // Flag follows the kind of work that was running
          if (i_array_busy) begin
            sys_next.sus_req = 1'b1;
            sys_next.sr_mid.erase_suspended_flag = i_array_erasing; // RULE_16
            sys_next.sr_mid.program_suspended_flag = !i_array_erasing; // RULE_16
          end
        end
        `OP_RESUME: begin
          sys_next.res_req = 1'b1;
          sys_next.sr_mid.erase_suspended_flag = 1'b0; // RULE_16
          sys_next.sr_mid.program_suspended_flag = 1'b0;
        end
        `OP_ENTER_FOUR_WIRE: begin
          // Ignored unless quad enable is already set
          if (sys_reg.sr_mid.quad_enable_bit) begin // RULE_12
            sys_next.four_wire = 1'b1;
          end
        end
        `OP_EXIT_FOUR_WIRE: begin
          sys_next.four_wire = 1'b0;
        end
        `OP_ENTER_ADDR4: begin
          sys_next.sr_high.current_address_mode = 1'b1; // RULE_17
        end
        `OP_EXIT_ADDR4: begin
          sys_next.sr_high.current_address_mode = 1'b0; // RULE_17
        end
        default: begin
          // Reads and unknown codes change nothing
        end
      endcase
    end
    // Busy is live; snapshot moves only with a request, so it stands for the link
    sys_next.sr_low.busy_flag = busy_now; // RULE_01
    if (new_req) begin
      sys_next.snap = {sys_next.sr_high, sys_next.sr_mid, sys_next.sr_low};
      sys_next.snap[`SNAP_HIGH_LSB + 4 -: 2] = 2'b00; // RULE_24
    end
  end

  // System side registers; power-up clears the protect pair to 00
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      sys_reg <= '0; // RULE_09
      sys_reg.init <= 1'b1;
    end else begin
      sys_reg <= sys_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    o_link_busy = link_reg.busy;
    o_rd_valid = link_reg.rd_valid;
    o_rd_data = link_reg.rd_data;
    o_array_go = sys_reg.go;
    o_array_op = sys_reg.op;
    o_suspend_req = sys_reg.sus_req;
    o_resume_req = sys_reg.res_req;
    o_dpb_set_all = sys_reg.dpb_set; // RULE_22
    // Block-protect guard only in the block scheme
    o_bp_enable = !sys_reg.sr_high.protection_scheme_select; // RULE_04 RULE_21
    o_block_protect_field = sys_reg.sr_low.block_protect_field; // RULE_15
    o_complement_protect = sys_reg.sr_mid.complement_protect;
    o_security_lock = sys_reg.sr_mid.security_lock; // RULE_14
    o_pins_quad = sys_reg.sr_mid.quad_enable_bit; // RULE_11
    o_hold_en = !sys_reg.sr_mid.quad_enable_bit
      && !sys_reg.sr_high.hold_or_reset_sel; // RULE_20
    o_reset_pin_en = !sys_reg.sr_mid.quad_enable_bit
      && sys_reg.sr_high.hold_or_reset_sel; // RULE_20
    o_four_wire_mode = sys_reg.four_wire;
    o_addr4_mode = sys_reg.sr_high.current_address_mode; // RULE_17 RULE_19
    o_drive_strength = sys_reg.sr_high.drive_strength; // RULE_23
  end
endmodule : flash_status_protection_regs

// ==== testbench/flash_status_asserts.sv ====
// Checker for the flash status bank: link handshake and protection relations.
// Assumes it is bound to the bank's top module and sees only its ports.
module flash_status_asserts #(
  parameter int SR_WRITE_CYCLES = 16
) (
  // Clocks and reset
  input wire logic i_clk_sys, i_nrst, i_clk_link,
  // Link handshake
  input wire logic i_cmd_valid, o_link_busy, o_rd_valid,
  // Array and protection state
  input wire logic o_array_go, o_dpb_set_all, o_bp_enable, o_complement_protect,
  input wire logic [7:0] o_array_op,
  input wire logic [4:0] o_block_protect_field,
  input wire logic [2:0] o_security_lock,
  input wire logic o_pins_quad, o_hold_en, o_reset_pin_en, o_four_wire_mode
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Link handshake
  // ----------------------------------------
  // An instruction is taken when offered while idle
  sequence s_taken;
    i_cmd_valid && !o_link_busy;
  endsequence
  chk_take_busy: assert property (@(posedge i_clk_link) disable iff (!i_nrst)
    s_taken |=> o_link_busy) else $error("busy not raised");
  chk_answer_bound: assert property (@(posedge i_clk_link) disable iff (!i_nrst)
    s_taken |-> ##[1:30] o_rd_valid) else $error("answer missing");
  chk_answer_pulse: assert property (@(posedge i_clk_link) disable iff (!i_nrst)
    o_rd_valid |-> !o_link_busy ##1 !o_rd_valid) else $error("answer not one pulse");
  // ----------------------------------------
  // Protection state
  // ----------------------------------------
  chk_chip_gate: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (o_array_go && o_array_op == 8'hC7 && o_bp_enable) |-> (o_complement_protect ?
    o_block_protect_field[2:0] == 3'h7 : o_block_protect_field[2:0] == 3'h0))
    else $error("bad chip erase grant");
  chk_quad_pins: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    o_pins_quad |-> !o_hold_en && !o_reset_pin_en) else $error("pin function with quad");
  chk_pin_select: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    !o_pins_quad |-> o_hold_en ^ o_reset_pin_en) else $error("no pin function");
  chk_quad_held: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    $fell(o_pins_quad) |-> !$past(o_four_wire_mode)) else $error("quad dropped in four-wire");
  chk_lock_sticky: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    ($past(o_security_lock) & ~o_security_lock) == 3'h0) else $error("lock bit cleared");
  chk_scheme_sticky: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    !$rose(o_bp_enable)) else $error("block mode returned");
  chk_dpb_init: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    o_dpb_set_all |-> !o_bp_enable ##1 !o_dpb_set_all) else $error("bad dynamic set pulse");
endmodule : flash_status_asserts

bind flash_status_protection_regs flash_status_asserts #(.SR_WRITE_CYCLES(SR_WRITE_CYCLES))
  u_chk (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_clk_link(i_clk_link),
  .i_cmd_valid(i_cmd_valid), .o_link_busy(o_link_busy), .o_rd_valid(o_rd_valid),
  .o_array_go(o_array_go), .o_dpb_set_all(o_dpb_set_all), .o_bp_enable(o_bp_enable),
  .o_complement_protect(o_complement_protect), .o_array_op(o_array_op),
  .o_block_protect_field(o_block_protect_field), .o_security_lock(o_security_lock),
  .o_pins_quad(o_pins_quad), .o_hold_en(o_hold_en), .o_reset_pin_en(o_reset_pin_en),
  .o_four_wire_mode(o_four_wire_mode));

// ==== testbench/flash_host_model.sv ====
// Host model: hands one instruction at a time to the bank on the link clock.
// Assumes one xfer call at a time, after reset.
module flash_host_model (
  // Link clock and answer from the bank
  input wire logic i_clk_link,
  input wire logic i_rd_valid,
  input wire logic [23:0] i_rd_data,
  // Instruction toward the bank
  output logic o_cmd_valid,
  output flash_status_pkg::cmd_t o_cmd
);
  timeunit 1ns;
  timeprecision 100ps;
  import flash_status_pkg::*;

  // Idle outputs at time zero
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd = '0;
  end

  // Offer one instruction for one edge, then await the answer
  task automatic xfer(input logic [7:0] op, input logic [23:0] d, input logic [1:0] n,
                      output logic [23:0] rd, output logic ok);
    int i;
    @(posedge i_clk_link);
    #1;
    o_cmd = '{opcode: op, data: d, nbytes: n};
    o_cmd_valid = 1'b1;
    @(posedge i_clk_link);
    #1;
    o_cmd_valid = 1'b0;
    // Released lines never keep the old value
    o_cmd = ~o_cmd;
    for (i = 0; i < 40; i++) begin
      @(posedge i_clk_link);
      #1;
      if (i_rd_valid === 1'b1) break;
    end
    ok = (i < 40);
    rd = i_rd_data;
  endtask : xfer
endmodule : flash_host_model

// ==== testbench/tb.sv ====
// Testbench for the flash status bank: instruction sequences with expected values.
// Assumes the host model and the bound checker are compiled with it.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import flash_status_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic i_clk_sys, i_nrst, i_dev_reset, i_array_busy, i_array_erasing, i_wp_n, i_clk_link;
  logic i_cmd_valid, o_link_busy, o_rd_valid, o_array_go, o_suspend_req, o_resume_req;
  logic o_dpb_set_all, o_bp_enable, o_complement_protect, o_pins_quad, o_hold_en;
  logic o_reset_pin_en, o_four_wire_mode, o_addr4_mode;
  cmd_t i_cmd;
  logic [23:0] o_rd_data, rd;
  logic [7:0] o_array_op;
  logic [4:0] o_block_protect_field;
  logic [2:0] o_security_lock;
  logic [1:0] o_drive_strength;
  logic [16:0] pat [4] = '{17'h0001C, 17'h10000, 17'h1401C, 17'h04000};
  int n_mismatch = 0, total_checks = 0, n_go = 0, n_dpb = 0, n0;

  flash_status_protection_regs #(.SR_WRITE_CYCLES(2)) DUT (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_dev_reset(i_dev_reset),
    .i_array_busy(i_array_busy), .i_array_erasing(i_array_erasing), .i_wp_n(i_wp_n),
    .i_clk_link(i_clk_link), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
    .o_link_busy(o_link_busy), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
    .o_array_go(o_array_go), .o_array_op(o_array_op), .o_suspend_req(o_suspend_req),
    .o_resume_req(o_resume_req), .o_dpb_set_all(o_dpb_set_all), .o_bp_enable(o_bp_enable),
    .o_block_protect_field(o_block_protect_field), .o_security_lock(o_security_lock),
    .o_complement_protect(o_complement_protect), .o_pins_quad(o_pins_quad),
    .o_hold_en(o_hold_en), .o_reset_pin_en(o_reset_pin_en),
    .o_four_wire_mode(o_four_wire_mode), .o_addr4_mode(o_addr4_mode),
    .o_drive_strength(o_drive_strength));
  flash_host_model host (.i_clk_link(i_clk_link), .i_rd_valid(o_rd_valid),
    .i_rd_data(o_rd_data), .o_cmd_valid(i_cmd_valid), .o_cmd(i_cmd));

  // Clocks: system 40 ns, link 12 ns with an unrelated phase
  initial begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    i_clk_link = 1'b0;
    #3.7;
    forever #6 i_clk_link = ~i_clk_link;
  end
  // Count array and dynamic-set pulses
  always @(posedge i_clk_sys) begin
    if ((o_array_go | o_suspend_req | o_resume_req) === 1'b1) n_go++;
    if (o_dpb_set_all === 1'b1) n_dpb++;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk_reg(input logic [23:0] got, input logic [23:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, m, got, exp);
    end
  endtask : chk_reg
  task automatic chk_out(input logic [7:0] got, input logic [7:0] exp, input string m);
    chk_reg({16'h0, got}, {16'h0, exp}, m);
  endtask : chk_out
  task automatic send(input logic [7:0] op, input logic [23:0] d, input logic [1:0] n);
    logic ok;
    host.xfer(op, d, n, rd, ok);
    chk_out({7'h0, ok}, 8'h01, "answer");
  endtask : send
  // Enabled status write, wait out the busy time, then read back
  task automatic wsr(input logic [7:0] op, input logic [23:0] d, input logic [1:0] n);
    send(8'h06, 24'h0, 2'd0);
    send(op, d, n);
    repeat (4) @(posedge i_clk_sys);
    send(8'h05, 24'h0, 2'd0);
  endtask : wsr
  task automatic pwr();
    @(posedge i_clk_sys) #1 i_nrst = 1'b0;
    repeat (16) @(posedge i_clk_sys);
    #1 i_nrst = 1'b1;
    repeat (2) @(posedge i_clk_sys);
  endtask : pwr
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    {i_nrst, i_dev_reset, i_array_busy, i_array_erasing, i_wp_n} = 5'b00001;
    pwr();
    send(8'h05, 24'h0, 2'd0);
    chk_reg(rd, 24'h000000, "reset values");
    chk_out({6'h0, o_hold_en, o_reset_pin_en}, 8'h02, "hold pin");
    send(8'h01, 24'h7C, 2'd1);
    send(8'h05, 24'h0, 2'd0);
    chk_reg(rd, 24'h000000, "no latch");
    wsr(8'h01, 24'h7F, 2'd1);
    chk_reg(rd, 24'h00007C, "protect write");
    chk_out({3'h0, o_block_protect_field}, 8'h1F, "protect out");
    send(8'hC7, 24'h0, 2'd0);
    for (int k = 0; k < 4; k++) begin
      wsr(8'h01, {8'h0, pat[k][15:0]}, 2'd2);
      chk_reg(rd, {8'h0, pat[k][15:0]}, "two bytes");
      n0 = n_go;
      send(8'h06, 24'h0, 2'd0);
      send(8'hC7, 24'h0, 2'd0);
      repeat (4) @(posedge i_clk_sys);
      chk_out(8'(n_go - n0), {7'h0, pat[k][16]}, "chip erase");
    end
    wsr(8'h01, 24'h80, 2'd2);
    @(posedge i_clk_sys) #1 i_wp_n = 1'b0;
    wsr(8'h01, 24'h84, 2'd1);
    chk_reg(rd, 24'h000080, "pin low");
    @(posedge i_clk_sys) #1 i_wp_n = 1'b1;
    wsr(8'h01, 24'h84, 2'd1);
    chk_reg(rd, 24'h000084, "pin high");
    for (int d = 0; d < 4; d++) begin
      wsr(8'h11, {16'h0, 1'b0, d[1:0], 5'b11000}, 2'd1);
      chk_out(rd[23:16], {1'b0, d[1:0], 5'h0}, "drive read");
      chk_out({6'h0, o_drive_strength}, {6'h0, d[1:0]}, "drive out");
    end
    wsr(8'h11, 24'h80, 2'd1);
    chk_out({6'h0, o_hold_en, o_reset_pin_en}, 8'h01, "reset pin");
    send(8'h38, 24'h0, 2'd0);
    chk_out({7'h0, o_four_wire_mode}, 8'h00, "entry ignored");
    wsr(8'h31, 24'h02, 2'd1);
    chk_out({5'h0, o_pins_quad, o_hold_en, o_reset_pin_en}, 8'h04, "quad pins");
    send(8'h38, 24'h0, 2'd0);
    wsr(8'h31, 24'h00, 2'd1);
    chk_out({6'h0, o_four_wire_mode, rd[9]}, 8'h03, "quad held");
    send(8'hFF, 24'h0, 2'd0);
    wsr(8'h31, 24'h08, 2'd1);
    wsr(8'h31, 24'h00, 2'd1);
    chk_out(rd[15:8], 8'h08, "locks");
    for (int e = 1; e >= 0; e--) begin
      @(posedge i_clk_sys) #1 {i_array_busy, i_array_erasing} = {1'b1, e[0]};
      send(8'h05, 24'h0, 2'd0);
      chk_out({7'h0, rd[0]}, 8'h01, "busy flag");
      send(8'h75, 24'h0, 2'd0);
      @(posedge i_clk_sys) #1 i_array_busy = 1'b0;
      send(8'h05, 24'h0, 2'd0);
      chk_out({6'h0, rd[15], rd[10]}, {6'h0, e[0], ~e[0]}, "suspend");
      send(8'h7A, 24'h0, 2'd0);
      send(8'h05, 24'h0, 2'd0);
      chk_out({6'h0, rd[15], rd[10]}, 8'h00, "resume");
    end
    chk_out(8'(n_go - n0), 8'h04, "pulses");
    wsr(8'h11, 24'h06, 2'd1);
    n0 = n_dpb;
    @(posedge i_clk_sys) #1 i_dev_reset = 1'b1;
    @(posedge i_clk_sys) #1 i_dev_reset = 1'b0;
    repeat (4) @(posedge i_clk_sys);
    chk_out({5'h0, o_addr4_mode, o_bp_enable, 1'(n_dpb - n0)}, 8'h05, "init");
    send(8'hE9, 24'h0, 2'd0);
    wsr(8'h11, 24'h00, 2'd1);
    chk_out(rd[23:16], 8'h04, "scheme");
    wsr(8'h01, 24'h0100, 2'd2);
    wsr(8'h01, 24'h7C, 2'd1);
    chk_out(rd[7:0], 8'h00, "lock-down");
    pwr();
    send(8'h05, 24'h0, 2'd0);
    chk_reg(rd, 24'h000000, "power cycle");
    wsr(8'h01, 24'h0180, 2'd2);
    wsr(8'h01, 24'h00, 2'd1);
    chk_out(rd[7:0], 8'h80, "permanent lock");
    test_done();
  end
  // Watchdog well beyond the expected run
  initial begin
    #400us;
    n_mismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done();
  end
endmodule : tb
